//--- mpbr_pkg.sv
// Package for the motor drive block: register offsets, reset values, timing counts.
// Assumes a 250 MHz system clock.
package mpbr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLOCK_HZ = 250_000_000;
  localparam int unsigned PWM_UNIT_HZ = 1000;
  localparam int unsigned TENTH_MS_US = 100;
  localparam int unsigned TENTH_MS_CYCLES = CLOCK_HZ / 1_000_000 * TENTH_MS_US;
  localparam int unsigned CAL_RUN_MS = 1500;
  localparam int unsigned CAL_RUN_TENTHS = CAL_RUN_MS * 10;

  // ****************************************
  // Configuration variable map
  // ****************************************
  localparam logic [7:0] ADDR_START_VOLTAGE = 8'h02;
  localparam logic [7:0] ADDR_PWM_FREQ = 8'h09;
  localparam logic [7:0] ADDR_REG_CONFIG = 8'h31;
  localparam logic [7:0] ADDR_SLOW_CUTOFF = 8'h33;
  localparam logic [7:0] ADDR_SLOW_GAIN = 8'h34;
  localparam logic [7:0] ADDR_EMF_REF = 8'h35;
  localparam logic [7:0] ADDR_MAIN_GAIN = 8'h36;
  localparam logic [7:0] ADDR_INERTIA = 8'h37;
  localparam logic [7:0] ADDR_LOW_STRENGTH = 8'h38;
  localparam logic [7:0] ADDR_PERIOD_LOW = 8'h74;
  localparam logic [7:0] ADDR_PERIOD_TOP = 8'h75;
  localparam logic [7:0] ADDR_GAP_LOW = 8'h76;
  localparam logic [7:0] ADDR_GAP_TOP = 8'h77;

  localparam logic [7:0] RST_START_VOLTAGE = 8'h03;
  localparam logic [7:0] RST_PWM_FREQ = 8'h28;
  localparam logic [7:0] RST_REG_CONFIG = 8'h01;
  localparam logic [7:0] RST_SLOW_CUTOFF = 8'h0a;
  localparam logic [7:0] RST_SLOW_GAIN = 8'h0a;
  localparam logic [7:0] RST_EMF_REF = 8'h82;
  localparam logic [7:0] RST_MAIN_GAIN = 8'h32;
  localparam logic [7:0] RST_INERTIA = 8'h64;
  localparam logic [7:0] RST_LOW_STRENGTH = 8'hff;
  localparam logic [7:0] RST_PERIOD_LOW = 8'h32;
  localparam logic [7:0] RST_PERIOD_TOP = 8'h96;
  localparam logic [7:0] RST_GAP_LOW = 8'h0f;
  localparam logic [7:0] RST_GAP_TOP = 8'h14;

  localparam int unsigned REG_ENABLE_BIT = 0;
  localparam logic [7:0] PWM_MIN = 8'h0a;
  localparam logic [7:0] PWM_MAX = 8'h32;
  localparam logic [7:0] PERIOD_MIN = 8'h32;
  localparam logic [7:0] PERIOD_MAX = 8'hc8;
  localparam logic [7:0] GAP_MIN = 8'h0a;
  localparam logic [7:0] GAP_MAX = 8'h28;
  localparam logic [7:0] CAL_ARM_VALUE = 8'h00;
  localparam logic [7:0] SPEED_TOP = 8'h7e;

  // Configuration write or read access
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] data;
  } mpbr_cfg_t;

  typedef enum logic [1:0] {
    MPBR_DRIVE = 2'b00,
    MPBR_GAP = 2'b01,
    MPBR_CAL = 2'b10
  } mpbr_state_t;

endpackage : mpbr_pkg

//--- mpbr_regulator.sv
// Motor PWM generator with back-EMF sampling, load regulation and calibration run.
// Assumes configuration accesses and ADC results are synchronous to i_clock.
// Overview of operation
// - PWM frequency is the pwm register times 1 kHz, values 10 to 50.
// - PWM frequency defaults to 40 kHz.
// - Motor is periodically switched off to measure back-EMF.
// - Period at speed step 1 is low-speed period times 0.1 ms, 50..200.
// - Period at top speed is top-speed period times 0.1 ms, 50..200.
// - Gap at speed step 1 is low-speed gap times 0.1 ms, 10..40.
// - Gap at top speed is top-speed gap times 0.1 ms, 10..40.
// - Config bit 0 low disables regulation; drive is open loop.
// - Reference level is the back-EMF at maximum revolutions, scales target.
// - Slow gain applies from speed step 1, separate from main gain.
// - Slow gain up to cutoff step, then ramps to main gain.
// - Low-speed strength scales regulation at low steps.
// - Armed and key 1 on: full speed for 1.5 s, commands ignored.
// - After the run, stop and store parameters into registers 51..55.
// - Registers reset to the documented factory defaults.
// - Inertia parameter filters the regulation loop correction.
`timescale 1ns/1ps
module mpbr_regulator #(
  parameter int unsigned CAL_TENTHS = mpbr_pkg::CAL_RUN_TENTHS,
  parameter int unsigned TENTH_CYCLES = mpbr_pkg::TENTH_MS_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire mpbr_pkg::mpbr_cfg_t i_cfg,
  output logic [7:0] o_cfg_rdata,
  input wire logic [7:0] i_speed_step,
  input wire logic i_key1,
  input wire logic [7:0] i_emf_sample,
  output logic o_emf_sample_strobe,
  output logic o_motor_pwm,
  output logic o_motor_off,
  output logic o_cal_busy
);

  if (CAL_TENTHS < 1 || CAL_TENTHS > 65536 || TENTH_CYCLES < 2 || TENTH_CYCLES > 65536)
  begin : g_bad_counts
    $error("mpbr_regulator: count parameters out of range");
  end

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta, rst_n;
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // Configuration variables
  // ****************************************
  logic [7:0] start_voltage, pwm_frequency_khz, regulation_config;
  logic [7:0] slow_gain_cutoff_step, slow_speed_gain, emf_reference_level;
  logic [7:0] main_regulation_gain, motor_inertia_param, low_speed_regulation_strength;
  logic [7:0] sample_period_low_speed, sample_period_top_speed;
  logic [7:0] sample_gap_low_speed, sample_gap_top_speed;
  logic cal_done;
  logic [7:0] cal_ref, cal_gain;
  wire wr = i_cfg.write;
  wire [7:0] wa = i_cfg.addr;
  wire [7:0] wd = i_cfg.data;
  wire pwm_ok = wd >= mpbr_pkg::PWM_MIN && wd <= mpbr_pkg::PWM_MAX;
  wire per_ok = wd >= mpbr_pkg::PERIOD_MIN && wd <= mpbr_pkg::PERIOD_MAX;
  wire gap_ok = wd >= mpbr_pkg::GAP_MIN && wd <= mpbr_pkg::GAP_MAX;

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_voltage <= mpbr_pkg::RST_START_VOLTAGE;
      pwm_frequency_khz <= mpbr_pkg::RST_PWM_FREQ;
      regulation_config <= mpbr_pkg::RST_REG_CONFIG;
      slow_gain_cutoff_step <= mpbr_pkg::RST_SLOW_CUTOFF;
      slow_speed_gain <= mpbr_pkg::RST_SLOW_GAIN;
      emf_reference_level <= mpbr_pkg::RST_EMF_REF;
      main_regulation_gain <= mpbr_pkg::RST_MAIN_GAIN;
      motor_inertia_param <= mpbr_pkg::RST_INERTIA;
      low_speed_regulation_strength <= mpbr_pkg::RST_LOW_STRENGTH;
      sample_period_low_speed <= mpbr_pkg::RST_PERIOD_LOW;
      sample_period_top_speed <= mpbr_pkg::RST_PERIOD_TOP;
      sample_gap_low_speed <= mpbr_pkg::RST_GAP_LOW;
      sample_gap_top_speed <= mpbr_pkg::RST_GAP_TOP;
    end
    else if (cal_done)
    begin
      slow_gain_cutoff_step <= mpbr_pkg::RST_SLOW_CUTOFF;
      slow_speed_gain <= cal_gain;
      emf_reference_level <= cal_ref;
      main_regulation_gain <= cal_gain;
      motor_inertia_param <= mpbr_pkg::RST_INERTIA;
    end
    else if (wr)
    begin
      case (wa)
        mpbr_pkg::ADDR_START_VOLTAGE: start_voltage <= wd;
        mpbr_pkg::ADDR_PWM_FREQ: if (pwm_ok) pwm_frequency_khz <= wd;
        mpbr_pkg::ADDR_REG_CONFIG: regulation_config <= wd;
        mpbr_pkg::ADDR_SLOW_CUTOFF: slow_gain_cutoff_step <= wd;
        mpbr_pkg::ADDR_SLOW_GAIN: slow_speed_gain <= wd;
        mpbr_pkg::ADDR_EMF_REF: emf_reference_level <= wd;
        mpbr_pkg::ADDR_MAIN_GAIN: main_regulation_gain <= wd;
        mpbr_pkg::ADDR_INERTIA: motor_inertia_param <= wd;
        mpbr_pkg::ADDR_LOW_STRENGTH: low_speed_regulation_strength <= wd;
        mpbr_pkg::ADDR_PERIOD_LOW: if (per_ok) sample_period_low_speed <= wd;
        mpbr_pkg::ADDR_PERIOD_TOP: if (per_ok) sample_period_top_speed <= wd;
        mpbr_pkg::ADDR_GAP_LOW: if (gap_ok) sample_gap_low_speed <= wd;
        mpbr_pkg::ADDR_GAP_TOP: if (gap_ok) sample_gap_top_speed <= wd;
        default: ;
      endcase
    end
  end

  logic [7:0] next_rdata;
  always_comb
  begin
    case (wa)
      mpbr_pkg::ADDR_START_VOLTAGE: next_rdata = start_voltage;
      mpbr_pkg::ADDR_PWM_FREQ: next_rdata = pwm_frequency_khz;
      mpbr_pkg::ADDR_REG_CONFIG: next_rdata = regulation_config;
      mpbr_pkg::ADDR_SLOW_CUTOFF: next_rdata = slow_gain_cutoff_step;
      mpbr_pkg::ADDR_SLOW_GAIN: next_rdata = slow_speed_gain;
      mpbr_pkg::ADDR_EMF_REF: next_rdata = emf_reference_level;
      mpbr_pkg::ADDR_MAIN_GAIN: next_rdata = main_regulation_gain;
      mpbr_pkg::ADDR_INERTIA: next_rdata = motor_inertia_param;
      mpbr_pkg::ADDR_LOW_STRENGTH: next_rdata = low_speed_regulation_strength;
      mpbr_pkg::ADDR_PERIOD_LOW: next_rdata = sample_period_low_speed;
      mpbr_pkg::ADDR_PERIOD_TOP: next_rdata = sample_period_top_speed;
      mpbr_pkg::ADDR_GAP_LOW: next_rdata = sample_gap_low_speed;
      mpbr_pkg::ADDR_GAP_TOP: next_rdata = sample_gap_top_speed;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
      o_cfg_rdata <= 8'h00;
    else if (i_cfg.read)
      o_cfg_rdata <= next_rdata;
  end

  // ****************************************
  // Calibration arming and run
  // ****************************************
  logic armed, key1_q, cal_busy, tenth_pulse;
  logic [15:0] cal_tenths;
  wire key1_rise = i_key1 && !key1_q;
  wire arm_write = wr && wa == mpbr_pkg::ADDR_MAIN_GAIN && wd == mpbr_pkg::CAL_ARM_VALUE
    && i_speed_step == 8'h00 && !i_key1;
  assign cal_done = cal_busy && tenth_pulse && cal_tenths == 16'(CAL_TENTHS - 1);

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed <= 1'b0;
      key1_q <= 1'b0;
      cal_busy <= 1'b0;
      cal_tenths <= 16'h0000;
    end
    else
    begin
      key1_q <= i_key1;
      if (arm_write)
        armed <= 1'b1;
      else if (key1_rise || (wr && wa == mpbr_pkg::ADDR_MAIN_GAIN))
        armed <= 1'b0;
      if (armed && key1_rise)
      begin
        cal_busy <= 1'b1;
        cal_tenths <= 16'h0000;
      end
      else if (cal_done)
        cal_busy <= 1'b0;
      else if (cal_busy && tenth_pulse)
        cal_tenths <= cal_tenths + 16'h0001;
    end
  end
  assign o_cal_busy = cal_busy;

  // ****************************************
  // Speed step, period and gap interpolation
  // ****************************************
  wire [7:0] speed = cal_busy ? mpbr_pkg::SPEED_TOP : i_speed_step;
  wire [7:0] step_c = speed > mpbr_pkg::SPEED_TOP ? mpbr_pkg::SPEED_TOP : speed;
  wire [7:0] frac = (step_c == 8'h00) ? 8'h00 : step_c - 8'h01;
  localparam logic [7:0] SPAN = mpbr_pkg::SPEED_TOP - 8'h01;
  wire signed [9:0] per_d = $signed({2'b00, sample_period_top_speed})
    - $signed({2'b00, sample_period_low_speed});
  wire signed [9:0] gap_d = $signed({2'b00, sample_gap_top_speed})
    - $signed({2'b00, sample_gap_low_speed});
  wire signed [18:0] per_p = per_d * $signed({1'b0, frac});
  wire signed [18:0] gap_p = gap_d * $signed({1'b0, frac});
  wire [7:0] period_tenths = 8'(sample_period_low_speed
    + 8'(per_p / $signed({11'd0, SPAN})));
  wire [7:0] gap_tenths = 8'(sample_gap_low_speed
    + 8'(gap_p / $signed({11'd0, SPAN})));

  // ****************************************
  // Measurement timing
  // ****************************************
  logic [15:0] tenth_cnt;
  logic [7:0] win_cnt;
  logic emf_strobe, pwm_out;
  mpbr_pkg::mpbr_state_t state;
  assign tenth_pulse = tenth_cnt == 16'(TENTH_CYCLES - 1);
  wire window_end = tenth_pulse && win_cnt + 8'h01 >= period_tenths;
  wire gap_end = tenth_pulse && win_cnt + 8'h01 >= gap_tenths;
  wire gap_next = (state == mpbr_pkg::MPBR_GAP) ? !gap_end : window_end;

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tenth_cnt <= 16'h0000;
      win_cnt <= 8'h00;
      state <= mpbr_pkg::MPBR_DRIVE;
      emf_strobe <= 1'b0;
    end
    else
    begin
      tenth_cnt <= tenth_pulse ? 16'h0000 : tenth_cnt + 16'h0001;
      emf_strobe <= 1'b0;
      case (state)
        mpbr_pkg::MPBR_DRIVE:
          if (window_end)
          begin
            state <= mpbr_pkg::MPBR_GAP;
            win_cnt <= 8'h00;
          end
          else if (tenth_pulse)
            win_cnt <= win_cnt + 8'h01;
        mpbr_pkg::MPBR_GAP:
          if (gap_end)
          begin
            state <= mpbr_pkg::MPBR_DRIVE;
            win_cnt <= gap_tenths;
            emf_strobe <= 1'b1;
          end
          else if (tenth_pulse)
            win_cnt <= win_cnt + 8'h01;
        default: state <= mpbr_pkg::MPBR_DRIVE;
      endcase
    end
  end
  assign o_emf_sample_strobe = emf_strobe;

  // ****************************************
  // Regulation loop
  // ****************************************
  wire reg_on = regulation_config[mpbr_pkg::REG_ENABLE_BIT] && !cal_busy;
  wire [15:0] target = 16'(step_c) * 16'(emf_reference_level) / 16'(mpbr_pkg::SPEED_TOP);
  wire [7:0] gain_ramp = (step_c <= slow_gain_cutoff_step) ? slow_speed_gain
    : 8'(16'(slow_speed_gain) + (16'(main_regulation_gain) - 16'(slow_speed_gain))
      * 16'(step_c - slow_gain_cutoff_step) / 16'(mpbr_pkg::SPEED_TOP));
  wire [7:0] gain_eff = (step_c > slow_gain_cutoff_step && gain_ramp > main_regulation_gain
    && main_regulation_gain >= slow_speed_gain) ? main_regulation_gain : gain_ramp;
  wire [7:0] strength = (step_c <= slow_gain_cutoff_step) ? low_speed_regulation_strength
    : 8'hff;
  wire signed [16:0] err = $signed({1'b0, target}) - $signed({9'd0, i_emf_sample});
  wire signed [33:0] corr_raw = err * $signed({9'd0, gain_eff}) * $signed({9'd0, strength});
  wire signed [15:0] corr = 16'(corr_raw >>> 14);
  logic signed [15:0] integ;
  wire signed [15:0] inertia_step = 16'((32'(corr) - 32'(integ))
    * 32'({1'b0, 8'hff - motor_inertia_param}) >>> 8);
  logic [7:0] duty;
  wire [7:0] base_duty = 8'(16'(step_c) * 16'h00ff / 16'(mpbr_pkg::SPEED_TOP));
  wire signed [16:0] duty_sum = $signed({9'd0, base_duty}) + 17'(integ);
  wire [7:0] open_duty = (step_c == 8'h00) ? 8'h00
    : (base_duty < start_voltage ? start_voltage : base_duty);
  wire [7:0] next_duty = cal_busy ? 8'hff
    : !reg_on ? open_duty
    : (step_c == 8'h00) ? 8'h00
    : duty_sum < 0 ? 8'h00 : duty_sum > 17'sd255 ? 8'hff : duty_sum[7:0];

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      integ <= 16'sd0;
      duty <= 8'h00;
      cal_ref <= mpbr_pkg::RST_EMF_REF;
      cal_gain <= mpbr_pkg::RST_MAIN_GAIN;
    end
    else if (emf_strobe)
    begin
      integ <= reg_on ? integ + inertia_step : 16'sd0;
      duty <= next_duty;
      if (cal_busy)
      begin
        cal_ref <= i_emf_sample > cal_ref ? i_emf_sample : cal_ref;
        cal_gain <= 8'(16'(mpbr_pkg::RST_MAIN_GAIN) * 16'(mpbr_pkg::RST_EMF_REF)
          / 16'(i_emf_sample | 8'h01));
      end
    end
    else if (cal_busy || step_c == 8'h00)
      duty <= next_duty;
  end

  // ****************************************
  // PWM generator
  // ****************************************
  logic [15:0] pwm_div;
  logic [7:0] pwm_phase;
  wire [15:0] pwm_tick_div = 16'(mpbr_pkg::CLOCK_HZ / mpbr_pkg::PWM_UNIT_HZ / 256);
  wire [15:0] pwm_limit = 16'(32'(pwm_tick_div) / 32'(pwm_frequency_khz));
  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwm_div <= 16'h0000;
      pwm_phase <= 8'h00;
      pwm_out <= 1'b0;
    end
    else
    begin
      pwm_div <= (pwm_div + 16'h0001 >= pwm_limit) ? 16'h0000 : pwm_div + 16'h0001;
      if (pwm_div + 16'h0001 >= pwm_limit)
        pwm_phase <= pwm_phase + 8'h01;
      pwm_out <= !gap_next && (pwm_phase < duty || duty == 8'hff);
    end
  end
  assign o_motor_pwm = pwm_out;
  assign o_motor_off = state == mpbr_pkg::MPBR_GAP;
endmodule : mpbr_regulator

//--- mpbr_motor_model.sv
// DC motor model: shaft speed follows the drive, back-EMF readable in the gap.
// Assumes the regulator drive outputs and the block clock.
`timescale 1ns/1ps
module mpbr_motor_model #(
  parameter logic [7:0] EMF_MAX = 8'h9c
) (
  input wire logic i_clock,
  input wire logic i_motor_pwm,
  input wire logic i_motor_off,
  output logic [7:0] o_emf
);
  logic [7:0] spin = 8'h00;
  logic [7:0] held = 8'h00;
  // Driven shaft speeds up, undriven shaft coasts down outside the gap and holds its speed in the gap
  always @(posedge i_clock)
  begin
    if (i_motor_off)
      held <= spin;
    if (i_motor_pwm && spin < EMF_MAX)
      spin <= spin + 8'h01;
    else if (!i_motor_pwm && !i_motor_off && spin != 8'h00)
      spin <= spin - 8'h01;
  end
  // Outside the gap the converter keeps its last gap reading
  assign o_emf = i_motor_off ? spin : held;
endmodule : mpbr_motor_model

//--- mpbr_regulator_asserts.sv
// Checker for the motor drive block, bound to its top module.
// Assumes the count parameters are handed on from the design.
`timescale 1ns/1ps
module mpbr_regulator_asserts #(
  parameter int unsigned CAL_TENTHS = mpbr_pkg::CAL_RUN_TENTHS,
  parameter int unsigned TENTH_CYCLES = mpbr_pkg::TENTH_MS_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire mpbr_pkg::mpbr_cfg_t i_cfg,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic [7:0] i_speed_step,
  input wire logic i_key1,
  input wire logic [7:0] i_emf_sample,
  input wire logic o_emf_sample_strobe,
  input wire logic o_motor_pwm,
  input wire logic o_motor_off,
  input wire logic o_cal_busy
);
  localparam int unsigned GAP_LO = 10 * TENTH_CYCLES;
  localparam int unsigned GAP_HI = 40 * TENTH_CYCLES;
  localparam int unsigned CAL_LEN = CAL_TENTHS * TENTH_CYCLES;
  int unsigned off_len;
  int unsigned cal_len;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  // Lengths of the current gap and calibration run
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      off_len <= 0;
      cal_len <= 0;
    end
    else
    begin
      off_len <= o_motor_off ? off_len + 1 : 0;
      cal_len <= o_cal_busy ? cal_len + 1 : 0;
    end
  end
  sequence s_gap_end;
    o_motor_off ##1 !o_motor_off;
  endsequence
  sequence s_strobe_near;
    ##[0:1] o_emf_sample_strobe;
  endsequence
  a_pwm_gap_off: assert property (o_motor_off |-> !o_motor_pwm)
    else $error("drive active in gap");
  a_strobe_gap_end: assert property (
    s_gap_end |-> $past(o_emf_sample_strobe) or s_strobe_near)
    else $error("no sample strobe at gap end");
  a_strobe_one_cycle: assert property (
    o_emf_sample_strobe |=> !o_emf_sample_strobe)
    else $error("sample strobe too long");
  a_gap_length: assert property (
    $fell(o_motor_off) |-> off_len >= GAP_LO - 2 && off_len <= GAP_HI + 2)
    else $error("gap length out of range");
  a_unmapped_zero: assert property (
    i_cfg.read && i_cfg.addr inside {8'h00, 8'h01, 8'hff} |=> o_cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!i_cfg.read |=> $stable(o_cfg_rdata))
    else $error("read data changed without read");
  a_cal_start: assert property (
    $rose(o_cal_busy) |-> $past(i_key1) && !$past(i_key1, 2))
    else $error("calibration start without key rise");
  a_cal_length: assert property (
    $fell(o_cal_busy) |->
      cal_len >= CAL_LEN - TENTH_CYCLES && cal_len <= CAL_LEN + TENTH_CYCLES)
    else $error("calibration run length wrong");
  a_cal_full_drive: assert property (
    o_cal_busy && $past(o_cal_busy, 2) && !o_motor_off && !$past(o_motor_off)
      |-> o_motor_pwm)
    else $error("calibration not at full drive");
endmodule : mpbr_regulator_asserts

bind mpbr_regulator mpbr_regulator_asserts #(
  .CAL_TENTHS(CAL_TENTHS), .TENTH_CYCLES(TENTH_CYCLES)) u_asserts (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_cfg(i_cfg), .o_cfg_rdata(o_cfg_rdata),
  .i_speed_step(i_speed_step), .i_key1(i_key1), .i_emf_sample(i_emf_sample),
  .o_emf_sample_strobe(o_emf_sample_strobe), .o_motor_pwm(o_motor_pwm),
  .o_motor_off(o_motor_off), .o_cal_busy(o_cal_busy));

//--- mpbr_regulator_test.sv
// Testbench for the motor drive block with a motor model on its drive outputs.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module mpbr_regulator_test;
  localparam int TC = 50;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  mpbr_pkg::mpbr_cfg_t cfg = '0;
  logic [7:0] speed = 8'h00;
  logic key1 = 1'b0;
  logic [7:0] rdata;
  logic [7:0] emf;
  logic strobe;
  logic pwm;
  logic off;
  logic busy;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [15:0] dflt [13] = '{16'h0203, 16'h0928, 16'h3101, 16'h330a, 16'h340a, 16'h3582,
    16'h3632, 16'h3764, 16'h38ff, 16'h7432, 16'h7596, 16'h760f, 16'h7714};
  logic [23:0] lim [5] = '{24'h09_0a32, 24'h74_32c8, 24'h75_32c8, 24'h76_0a28, 24'h77_0a28};
  mpbr_regulator #(.CAL_TENTHS(20), .TENTH_CYCLES(TC)) DUT (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_cfg(cfg), .o_cfg_rdata(rdata),
    .i_speed_step(speed), .i_key1(key1), .i_emf_sample(emf),
    .o_emf_sample_strobe(strobe), .o_motor_pwm(pwm), .o_motor_off(off), .o_cal_busy(busy));
  mpbr_motor_model u_motor (
    .i_clock(i_clock), .i_motor_pwm(pwm), .i_motor_off(off), .o_emf(emf));
  initial
  begin
    forever #2 i_clock = ~i_clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] near(input int a, input int b, input int t);
    return (a >= b - t && a <= b + t) ? 8'h01 : 8'h00;
  endfunction : near
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    cfg <= {1'b1, 1'b0, a, d};
    @(posedge i_clock);
    cfg <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clock);
    cfg <= {1'b0, 1'b1, a, 8'h00};
    @(posedge i_clock);
    cfg <= '0;
    @(posedge i_clock);
    #1;
    v = rdata;
  endtask : rd
  // Counts cycles until the gap output reaches the given level
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (off !== lvl && n < 20000)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
  endtask : span
  task automatic t_defaults;
    logic [7:0] v;
    foreach (dflt[i])
    begin
      rd(dflt[i][15:8], v);
      check(v, dflt[i][7:0]);
    end
    rd(8'h00, v);
    check(v, 8'h00);
  endtask : t_defaults
  task automatic t_ranges;
    logic [7:0] v;
    logic [7:0] old;
    foreach (lim[i])
    begin
      rd(lim[i][23:16], old);
      wr(lim[i][23:16], lim[i][15:8] - 8'h01);
      wr(lim[i][23:16], lim[i][7:0] + 8'h01);
      rd(lim[i][23:16], v);
      check(v, old);
      wr(lim[i][23:16], lim[i][15:8]);
      rd(lim[i][23:16], v);
      check(v, lim[i][15:8]);
      wr(lim[i][23:16], lim[i][7:0]);
      rd(lim[i][23:16], v);
      check(v, lim[i][7:0]);
    end
    wr(8'h31, 8'h00);
    rd(8'h31, v);
    check(v, 8'h00);
    wr(8'h31, 8'h01);
  endtask : t_ranges
  task automatic t_sample(input logic [7:0] sp, input int per, input int gap);
    int n;
    int g;
    int d;
    @(posedge i_clock);
    speed <= sp;
    span(1'b1, n);
    span(1'b0, n);
    span(1'b1, n);
    span(1'b0, g);
    span(1'b1, d);
    check(near(g, gap * TC, 2), 8'h01);
    check(near(g + d, per * TC, 2), 8'h01);
  endtask : t_sample
  task automatic t_interp;
    wr(8'h74, 8'h32);
    wr(8'h75, 8'haf);
    wr(8'h76, 8'h0a);
    wr(8'h77, 8'h23);
    t_sample(8'h01, 50, 10);
    t_sample(8'h33, 100, 20);
    t_sample(8'h7e, 175, 35);
  endtask : t_interp
  task automatic t_cal;
    logic [7:0] v;
    int n;
    wr(8'h33, 8'h05);
    wr(8'h37, 8'h20);
    @(posedge i_clock);
    speed <= 8'h00;
    key1 <= 1'b0;
    wr(8'h36, 8'h00);
    rd(8'h36, v);
    check(v, 8'h00);
    @(posedge i_clock);
    key1 <= 1'b1;
    @(posedge i_clock);
    #1;
    check({7'h00, busy}, 8'h01);
    n = 0;
    while (busy === 1'b1 && n < 5000)
    begin
      @(posedge i_clock);
      #1;
      n++;
      if (n == 100)
        check({7'h00, pwm | off}, 8'h01);
    end
    check(near(n, 20 * TC, TC), 8'h01);
    repeat (4) @(posedge i_clock);
    #1;
    check({7'h00, pwm}, 8'h00);
    rd(8'h33, v);
    check(v, 8'h0a);
    rd(8'h37, v);
    check(v, 8'h64);
    @(posedge i_clock);
    key1 <= 1'b0;
    repeat (2) @(posedge i_clock);
    key1 <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    check({7'h00, busy}, 8'h00);
  endtask : t_cal
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial
  begin
    #360_000;
    n_mismatch++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clock);
    t_defaults();
    t_ranges();
    t_interp();
    t_cal();
    results();
  end
endmodule : mpbr_regulator_test
